/* fspc_top.sv */
// Flash self-program control: Avalon-MM register file, unlock, read, latch load, program and erase sequencing
//
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Config select bit 1 steers reads and writes to the alternate space.
// - Alternate user IDs 0-3 read/write; device ID 5-6 and config 7-8 read-only.
// - Alternate-space read outside permitted ranges clears both data registers.
// - Word address is high bits 6-0 over low bits 7-0; high bit 7 reads 1.
// - Data word is low byte plus high bits 5-0; high bits 7-6 read 0.
// - Data registers unknown at power-up, kept on reset; address registers clear.
// - Latch-only bit 1: start loads only the addressed latch, no programming.
// - Latch-only bit 0: start loads latch then programs all latches.
// - Erase bit 1: start erases; hardware clears erase bit when done.
// - Latch-only bit ignored while erase is selected.
// - Error flag set on every start attempt; cleared on normal completion.
// - Program enable 0 inhibits all programming and erasing.
// - Start bit set-only by software, self-timed, cleared by hardware.
// - Read bit fetches the word in one cycle and self-clears.
// - Control register bit 7 reads as 1.
// - Unlock key is write-only, eight bits, zero after every reset.
// - Start accepted only after 55h then AAh written to the key.
// - Interrupted unlock loads no latch and starts no programming.
// - Every write or erase completion resets all latches to 3FFFh.
// - Upper ten address bits pick the row, lower five the latch.
module fspc_top #(
  parameter int LATCH_N = 32
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [fspc_pkg::ADDR_W-1:0] flash_addr_o,
  output logic flash_cfg_o,
  output logic flash_rd_o,
  input wire logic [fspc_pkg::DATA_W-1:0] flash_rd_data_i,
  output logic flash_prog_o,
  output logic flash_erase_o,
  output logic [fspc_pkg::ROW_W-1:0] flash_row_o,
  output logic [LATCH_N*fspc_pkg::DATA_W-1:0] flash_latch_data_o,
  input wire logic flash_done_i,
  output logic cpu_stall_o
);

  logic [7:0] data_low_ff;
  logic [fspc_pkg::DATA_HIGH_W-1:0] data_high_ff;
  logic [7:0] addr_low_ff;
  logic [fspc_pkg::ADDR_HIGH_W-1:0] addr_high_ff;
  logic [7:0] key_ff;
  logic config_space_select_ff;
  logic latch_only_load_ff;
  logic erase_ff;
  logic err_ff;
  logic program_enable_ff;
  logic rd_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic op_erase_ff;
  logic op_prog_ff;
  logic op_allowed_ff;
  logic prog_pulse_ff;
  logic erase_pulse_ff;
  logic [fspc_pkg::DATA_W-1:0] latch_ff [LATCH_N];
  fspc_pkg::fspc_state_e state_ff;
  fspc_pkg::fspc_unlock_e unlock_ff;

  logic busy;
  logic acc;
  logic wr_take;
  logic rd_take;
  logic [fspc_pkg::ADDR_W-1:0] word_addr;
  logic [fspc_pkg::LATCH_IDX_W-1:0] latch_idx;
  logic cfg_rd_ok;
  logic cfg_wr_ok;
  logic ctl_wr;
  logic key_wr;
  logic start_try;
  logic start_go;
  logic done_now;
  logic [7:0] ctl_rd;
  logic [31:0] nxt_rdata;

  assign word_addr = {addr_high_ff, addr_low_ff};
  assign latch_idx = word_addr[fspc_pkg::LATCH_IDX_W-1:0];
  assign busy = (state_ff != fspc_pkg::FSPC_IDLE);

  // Range checks inside the alternate space
  assign cfg_rd_ok = (word_addr <= fspc_pkg::CFG_UID_HI) ||
                     ((word_addr >= fspc_pkg::CFG_DEVID_LO) && (word_addr <= fspc_pkg::CFG_WORD_HI));
  assign cfg_wr_ok = (word_addr >= fspc_pkg::CFG_UID_LO) && (word_addr <= fspc_pkg::CFG_UID_HI);

  // Bus handshake: one wait cycle per access, and the bus holds off while flash is busy
  assign acc = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = acc & (~ack_ff | busy);
  assign wr_take = avs_write_i & ~avs_waitrequest_o;
  assign rd_take = avs_read_i & ~avs_waitrequest_o;
  assign avs_readdata_o = rdata_ff;
  assign cpu_stall_o = busy;

  assign ctl_wr = wr_take && (avs_address_i == fspc_pkg::OFS_CONTROL);
  assign key_wr = wr_take && (avs_address_i == fspc_pkg::OFS_UNLOCK_KEY);
  assign start_try = ctl_wr && avs_writedata_i[fspc_pkg::CTL_WR_BIT];
  // Start also needs the enable as it stands after this same write
  assign start_go = start_try && (unlock_ff == fspc_pkg::FSPC_UNLK_ARMED)
                    && avs_writedata_i[fspc_pkg::CTL_PROGRAM_ENABLE_BIT];
  assign done_now = ((state_ff == fspc_pkg::FSPC_KICK) && !op_prog_ff && !op_erase_ff) ||
                    ((state_ff == fspc_pkg::FSPC_KICK) && !op_allowed_ff) ||
                    ((state_ff == fspc_pkg::FSPC_WAIT) && flash_done_i);

  assign ctl_rd = {1'b1, config_space_select_ff, latch_only_load_ff, erase_ff, err_ff, program_enable_ff, busy, rd_ff};

  always_comb begin
    nxt_rdata = 32'h00000000;
    unique case (avs_address_i)
      fspc_pkg::OFS_DATA_LOW: nxt_rdata[7:0] = data_low_ff;
      fspc_pkg::OFS_DATA_HIGH: nxt_rdata[7:0] = {2'b00, data_high_ff};
      fspc_pkg::OFS_ADDR_LOW: nxt_rdata[7:0] = addr_low_ff;
      fspc_pkg::OFS_ADDR_HIGH: nxt_rdata[7:0] = {1'b1, addr_high_ff};
      fspc_pkg::OFS_CONTROL: nxt_rdata[7:0] = ctl_rd;
      default: nxt_rdata = 32'h00000000; // Unlock key is write-only; unmapped reads zero
    endcase
  end

  // Bus acknowledge and read data capture
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= acc & ~ack_ff & ~busy;
      if (avs_read_i && !ack_ff && !busy) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // Data registers carry no reset so a warm reset keeps them
  always_ff @(posedge clk_i) begin
    if (rd_ff) begin
      if (config_space_select_ff && !cfg_rd_ok) begin
        data_low_ff <= 8'h00;
        data_high_ff <= 6'h00;
      end else begin
        data_low_ff <= flash_rd_data_i[7:0];
        data_high_ff <= flash_rd_data_i[fspc_pkg::DATA_W-1:8];
      end
    end else if (wr_take && (avs_address_i == fspc_pkg::OFS_DATA_LOW)) begin
      data_low_ff <= avs_writedata_i[7:0];
    end else if (wr_take && (avs_address_i == fspc_pkg::OFS_DATA_HIGH)) begin
      data_high_ff <= avs_writedata_i[fspc_pkg::DATA_HIGH_W-1:0];
    end
  end

  // Address registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_low_ff <= fspc_pkg::ADDR_LOW_RST;
      addr_high_ff <= fspc_pkg::ADDR_HIGH_RST;
    end else begin
      if (wr_take && (avs_address_i == fspc_pkg::OFS_ADDR_LOW)) begin
        addr_low_ff <= avs_writedata_i[7:0];
      end
      if (wr_take && (avs_address_i == fspc_pkg::OFS_ADDR_HIGH)) begin
        addr_high_ff <= avs_writedata_i[fspc_pkg::ADDR_HIGH_W-1:0];
      end
    end
  end

  // Unlock key and sequence tracker; any other write breaks the pattern
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      key_ff <= fspc_pkg::KEY_RST;
      unlock_ff <= fspc_pkg::FSPC_UNLK_NONE;
    end else begin
      if (key_wr) begin
        key_ff <= avs_writedata_i[7:0];
        if (avs_writedata_i[7:0] == fspc_pkg::KEY_FIRST) begin
          unlock_ff <= fspc_pkg::FSPC_UNLK_HALF;
        end else if ((avs_writedata_i[7:0] == fspc_pkg::KEY_SECOND) &&
                     (unlock_ff == fspc_pkg::FSPC_UNLK_HALF)) begin
          unlock_ff <= fspc_pkg::FSPC_UNLK_ARMED;
        end else begin
          unlock_ff <= fspc_pkg::FSPC_UNLK_NONE;
        end
      end else if (wr_take) begin
        unlock_ff <= fspc_pkg::FSPC_UNLK_NONE;
      end
    end
  end

  // Control bits written by software
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      config_space_select_ff <= 1'b0;
      latch_only_load_ff <= 1'b0;
      program_enable_ff <= 1'b0;
    end else if (ctl_wr) begin
      config_space_select_ff <= avs_writedata_i[fspc_pkg::CTL_CONFIG_SPACE_SELECT_BIT];
      latch_only_load_ff <= avs_writedata_i[fspc_pkg::CTL_LATCH_ONLY_LOAD_BIT];
      program_enable_ff <= avs_writedata_i[fspc_pkg::CTL_PROGRAM_ENABLE_BIT];
    end
  end

  // Erase select: hardware clear on completion of an erase
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      erase_ff <= 1'b0;
    end else if (ctl_wr) begin
      erase_ff <= avs_writedata_i[fspc_pkg::CTL_ERASE_BIT];
    end else if (done_now && op_erase_ff) begin
      erase_ff <= 1'b0;
    end
  end

  // Error flag: a start attempt wins over any clear in the same cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      err_ff <= 1'b0;
    end else if (start_try) begin
      err_ff <= 1'b1;
    end else if (ctl_wr) begin
      err_ff <= avs_writedata_i[fspc_pkg::CTL_ERR_BIT];
    end else if (done_now) begin
      err_ff <= 1'b0;
    end
  end

  // Read strobe: set-only by software, cleared one cycle later
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_ff <= 1'b0;
    end else if (ctl_wr && avs_writedata_i[fspc_pkg::CTL_RD_BIT]) begin
      rd_ff <= 1'b1;
    end else begin
      rd_ff <= 1'b0;
    end
  end

  assign flash_addr_o = word_addr;
  assign flash_cfg_o = config_space_select_ff;
  assign flash_rd_o = rd_ff;
  assign flash_row_o = word_addr[fspc_pkg::ADDR_W-1:fspc_pkg::LATCH_IDX_W];
  assign flash_prog_o = prog_pulse_ff;
  assign flash_erase_o = erase_pulse_ff;

  // Operation sequencer; the start bit reads back as the busy state
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= fspc_pkg::FSPC_IDLE;
      op_erase_ff <= 1'b0;
      op_prog_ff <= 1'b0;
      op_allowed_ff <= 1'b0;
      prog_pulse_ff <= 1'b0;
      erase_pulse_ff <= 1'b0;
    end else begin
      prog_pulse_ff <= 1'b0;
      erase_pulse_ff <= 1'b0;
      unique case (state_ff)
        fspc_pkg::FSPC_IDLE: begin
          if (start_go) begin
            state_ff <= fspc_pkg::FSPC_KICK;
            op_erase_ff <= avs_writedata_i[fspc_pkg::CTL_ERASE_BIT];
            // Latch-only is ignored when an erase is selected
            op_prog_ff <= !avs_writedata_i[fspc_pkg::CTL_ERASE_BIT] &&
                          !avs_writedata_i[fspc_pkg::CTL_LATCH_ONLY_LOAD_BIT];
            op_allowed_ff <= !avs_writedata_i[fspc_pkg::CTL_CONFIG_SPACE_SELECT_BIT] || cfg_wr_ok;
          end
        end
        fspc_pkg::FSPC_KICK: begin
          if (done_now) begin
            state_ff <= fspc_pkg::FSPC_IDLE;
          end else begin
            state_ff <= fspc_pkg::FSPC_WAIT;
            prog_pulse_ff <= op_prog_ff;
            erase_pulse_ff <= op_erase_ff;
          end
        end
        fspc_pkg::FSPC_WAIT: begin
          if (flash_done_i) begin
            state_ff <= fspc_pkg::FSPC_IDLE;
          end
        end
        default: state_ff <= fspc_pkg::FSPC_IDLE;
      endcase
    end
  end

  // Write latches: loaded at the kick unless erasing or the alternate-space address is not writable, blanked after any write or erase
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < LATCH_N; i++) begin
        latch_ff[i] <= fspc_pkg::LATCH_BLANK;
      end
    end else if (done_now && (op_erase_ff || op_prog_ff)) begin
      for (int i = 0; i < LATCH_N; i++) begin
        latch_ff[i] <= fspc_pkg::LATCH_BLANK;
      end
    end else if ((state_ff == fspc_pkg::FSPC_KICK) && !op_erase_ff && op_allowed_ff) begin
      latch_ff[latch_idx] <= {data_high_ff, data_low_ff};
    end
  end

  genvar g;
  generate
    for (g = 0; g < LATCH_N; g++) begin : g_latch_out
      assign flash_latch_data_o[g*fspc_pkg::DATA_W +: fspc_pkg::DATA_W] = latch_ff[g];
    end
  endgenerate

endmodule

`default_nettype wire

/* fspc_pkg.sv */
// Package: register map, field positions, reset values and address ranges of the flash self-program control
package fspc_pkg;
  // Avalon byte offsets of the registers
  localparam logic [4:0] OFS_DATA_LOW = 5'h00;
  localparam logic [4:0] OFS_DATA_HIGH = 5'h04;
  localparam logic [4:0] OFS_ADDR_LOW = 5'h08;
  localparam logic [4:0] OFS_ADDR_HIGH = 5'h0C;
  localparam logic [4:0] OFS_CONTROL = 5'h10;
  localparam logic [4:0] OFS_UNLOCK_KEY = 5'h14;

  // Control register fields
  localparam int CTL_ONE_BIT = 7;
  localparam int CTL_CONFIG_SPACE_SELECT_BIT = 6;
  localparam int CTL_LATCH_ONLY_LOAD_BIT = 5;
  localparam int CTL_ERASE_BIT = 4;
  localparam int CTL_ERR_BIT = 3;
  localparam int CTL_PROGRAM_ENABLE_BIT = 2;
  localparam int CTL_WR_BIT = 1;
  localparam int CTL_RD_BIT = 0;

  // Widths
  localparam int ADDR_W = 15;
  localparam int DATA_W = 14;
  localparam int ADDR_HIGH_W = 7;
  localparam int DATA_HIGH_W = 6;
  localparam int LATCH_IDX_W = 5;
  localparam int ROW_W = 10;

  // Reset values
  localparam logic [7:0] KEY_RST = 8'h00;
  localparam logic [7:0] ADDR_LOW_RST = 8'h00;
  localparam logic [6:0] ADDR_HIGH_RST = 7'h00;
  localparam logic [13:0] LATCH_BLANK = 14'h3FFF;

  // Unlock pattern
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // Alternate space ranges, as offsets from the base of that space
  localparam logic [14:0] CFG_UID_LO = 15'h0000;
  localparam logic [14:0] CFG_UID_HI = 15'h0003;
  localparam logic [14:0] CFG_DEVID_LO = 15'h0005;
  localparam logic [14:0] CFG_DEVID_HI = 15'h0006;
  localparam logic [14:0] CFG_WORD_LO = 15'h0007;
  localparam logic [14:0] CFG_WORD_HI = 15'h0008;

  typedef enum logic [1:0] {
    FSPC_IDLE = 2'b00,
    FSPC_KICK = 2'b01,
    FSPC_WAIT = 2'b10
  } fspc_state_e;

  typedef enum logic [1:0] {
    FSPC_UNLK_NONE = 2'b00,
    FSPC_UNLK_HALF = 2'b01,
    FSPC_UNLK_ARMED = 2'b10
  } fspc_unlock_e;
endpackage

/* fspc_props.sv */
// Checker of the flash self-program control port behaviour
`timescale 1ns/10ps
`default_nettype none
module fspc_props #(
  parameter int LATCH_N = 32
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [fspc_pkg::ADDR_W-1:0] flash_addr_o,
  input wire logic flash_cfg_o,
  input wire logic flash_rd_o,
  input wire logic [fspc_pkg::DATA_W-1:0] flash_rd_data_i,
  input wire logic flash_prog_o,
  input wire logic flash_erase_o,
  input wire logic [fspc_pkg::ROW_W-1:0] flash_row_o,
  input wire logic [LATCH_N*fspc_pkg::DATA_W-1:0] flash_latch_data_o,
  input wire logic flash_done_i,
  input wire logic cpu_stall_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic rq;
  logic take_rd;
  assign rq = avs_read_i | avs_write_i;
  assign take_rd = avs_read_i & !avs_waitrequest_o;
  a_row_of_addr: assert property (flash_row_o == flash_addr_o[14:5])
    else $error("row select does not follow the word address");
  a_stall_blocks: assert property (cpu_stall_o && rq |-> avs_waitrequest_o)
    else $error("bus served while an operation runs");
  a_one_wait: assert property (rq && !$past(rq) && !cpu_stall_o |->
    avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bus answer not after one wait state");
  a_pulse_short: assert property (flash_prog_o || flash_erase_o |=> !flash_prog_o && !flash_erase_o)
    else $error("program or erase pulse longer than one cycle");
  a_op_stalls: assert property (flash_prog_o || flash_erase_o |-> cpu_stall_o)
    else $error("operation issued without stall");
  a_done_idle: assert property (flash_done_i && cpu_stall_o |=>
    !cpu_stall_o && flash_latch_data_o == {LATCH_N{fspc_pkg::LATCH_BLANK}})
    else $error("completion did not end the operation with blank latches");
  a_read_short: assert property (flash_rd_o |=> !flash_rd_o)
    else $error("array read longer than one cycle");
  a_alt_ro_safe: assert property ((flash_prog_o || flash_erase_o) && flash_cfg_o |->
    flash_addr_o <= 15'h0003)
    else $error("read-only alternate word modified");
  a_ctl_top_one: assert property (take_rd && avs_address_i == fspc_pkg::OFS_CONTROL |->
    avs_readdata_o[7])
    else $error("control bit 7 not read as one");
  a_adh_top_one: assert property (take_rd && avs_address_i == fspc_pkg::OFS_ADDR_HIGH |->
    avs_readdata_o[7])
    else $error("address high bit 7 not read as one");
  a_dah_top_zero: assert property (take_rd && avs_address_i == fspc_pkg::OFS_DATA_HIGH |->
    avs_readdata_o[7:6] == 2'h0)
    else $error("data high bits 7-6 not zero");
  a_key_reads_0: assert property (take_rd && avs_address_i == fspc_pkg::OFS_UNLOCK_KEY |->
    avs_readdata_o == 32'h0)
    else $error("unlock key readable");
endmodule
bind fspc_top fspc_props #(.LATCH_N(LATCH_N)) i_props (.clk_i(clk_i), .rstn_i(rstn_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .flash_addr_o(flash_addr_o), .flash_cfg_o(flash_cfg_o), .flash_rd_o(flash_rd_o),
  .flash_rd_data_i(flash_rd_data_i), .flash_prog_o(flash_prog_o), .flash_erase_o(flash_erase_o),
  .flash_row_o(flash_row_o), .flash_latch_data_o(flash_latch_data_o), .flash_done_i(flash_done_i),
  .cpu_stall_o(cpu_stall_o));
`default_nettype wire

/* fspc_flash_model.sv */
// Behavioural flash array: address-derived words and self-timed completion
`timescale 1ns/10ps
`default_nettype none
module fspc_flash_model #(
  parameter int DONE_DLY = 20
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [14:0] addr_i,
  input wire logic cfg_i,
  input wire logic rd_i,
  input wire logic prog_i,
  input wire logic erase_i,
  output logic [13:0] rd_data_o,
  output logic done_o
);
  logic tgl_ff;
  int cnt_ff;
  // Contents follow the address so the bench predicts them; outside a read the lines toggle every cycle
  assign rd_data_o = !rd_i ? {7{tgl_ff, !tgl_ff}} : cfg_i ? (addr_i[13:0] | 14'h2000) : (addr_i[13:0] ^ 14'h2AAA);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tgl_ff <= 1'b0;
      cnt_ff <= 0;
      done_o <= 1'b0;
    end else begin
      tgl_ff <= !tgl_ff;
      done_o <= (cnt_ff == 1);
      if (prog_i || erase_i) cnt_ff <= DONE_DLY;
      else if (cnt_ff != 0) cnt_ff <= cnt_ff - 1;
    end
  end
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench of the flash self-program control
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [4:0] DL = fspc_pkg::OFS_DATA_LOW;
  localparam logic [4:0] DH = fspc_pkg::OFS_DATA_HIGH;
  localparam logic [4:0] AL = fspc_pkg::OFS_ADDR_LOW;
  localparam logic [4:0] AH = fspc_pkg::OFS_ADDR_HIGH;
  localparam logic [4:0] CT = fspc_pkg::OFS_CONTROL;
  localparam logic [4:0] KY = fspc_pkg::OFS_UNLOCK_KEY;
  logic clk_i, rstn_i, avs_read_i, avs_write_i, avs_waitrequest_o, flash_cfg_o, flash_rd_o;
  logic flash_prog_o, flash_erase_o, flash_done_i, cpu_stall_o;
  logic [4:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [14:0] flash_addr_o;
  logic [13:0] flash_rd_data_i;
  logic [9:0] flash_row_o;
  logic [32*14-1:0] flash_latch_data_o;
  int n_fail, tests_run, n_prog, n_erase;
  fspc_top #(.LATCH_N(32)) i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .flash_addr_o(flash_addr_o),
    .flash_cfg_o(flash_cfg_o), .flash_rd_o(flash_rd_o), .flash_rd_data_i(flash_rd_data_i),
    .flash_prog_o(flash_prog_o), .flash_erase_o(flash_erase_o), .flash_row_o(flash_row_o),
    .flash_latch_data_o(flash_latch_data_o), .flash_done_i(flash_done_i), .cpu_stall_o(cpu_stall_o));
  fspc_flash_model i_flash (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(flash_addr_o), .cfg_i(flash_cfg_o),
    .rd_i(flash_rd_o), .prog_i(flash_prog_o), .erase_i(flash_erase_o), .rd_data_o(flash_rd_data_i),
    .done_o(flash_done_i));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = !clk_i;
  end
  always @(posedge clk_i) begin
    if (flash_prog_o === 1'b1) n_prog++;
    if (flash_erase_o === 1'b1) n_erase++;
  end
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request held until an edge with waitrequest low; one idle edge before the next request
  task automatic bus(input logic we, input logic [4:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= we;
    avs_read_i <= !we;
    // Waitrequest and read data are taken at the rising edge itself, before that edge's updates land
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0 && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (k >= 400) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d); bus(1'b1, a, d); endtask
  task automatic rd(input logic [4:0] a); bus(1'b0, a, 8'h00); endtask
  task automatic start(input logic [7:0] c);
    wr(KY, fspc_pkg::KEY_FIRST);
    wr(KY, fspc_pkg::KEY_SECOND);
    wr(CT, c);
  endtask
  task automatic sc_reset;
    rd(AL); check(q, 32'h00);
    rd(AH); check(q, 32'h80);
    rd(CT); check(q, 32'h80);
    rd(KY); check(q, 32'h00);
  endtask
  task automatic sc_regs;
    wr(AL, 8'hA5); wr(AH, 8'hFF); rd(AH); check(q, 32'hFF);
    check({17'h0, flash_addr_o}, 32'h7FA5);
    check({22'h0, flash_row_o}, 32'h3FD);
    wr(DH, 8'hFF); rd(DH); check(q, 32'h3F);
    wr(KY, 8'h12); rd(KY); check(q, 32'h00);
    wr(5'h18, 8'hFF); rd(5'h18); check(q, 32'h00);
  endtask
  task automatic sc_read;
    logic inr;
    wr(CT, 8'h00); wr(AH, 8'h01); wr(AL, 8'h23); wr(CT, 8'h01);
    rd(DL); check(q, 32'h89);
    rd(DH); check(q, 32'h2B);
    rd(CT); check(q, 32'h80);
    wr(AH, 8'h00);
    for (int i = 0; i < 10; i++) begin
      inr = (i <= 3) || (i >= 5 && i <= 8);
      wr(AL, i[7:0]); wr(CT, 8'h41);
      rd(DL); check(q, inr ? i : 0);
      rd(DH); check(q, inr ? 32'h20 : 32'h00);
    end
  endtask
  task automatic sc_latch;
    wr(AL, 8'h43); wr(DL, 8'h34); wr(DH, 8'h12); start(8'h26);
    rd(CT); check(q, 32'hA4);
    check({18'h0, flash_latch_data_o[3*14+:14]}, 32'h1234);
    check(n_prog, 0);
    wr(DL, 8'h77); wr(KY, 8'h55); wr(AL, 8'h43); wr(KY, 8'hAA); wr(CT, 8'h26);
    rd(CT); check(q, 32'hAC);
    check({18'h0, flash_latch_data_o[3*14+:14]}, 32'h1234);
    start(8'h22); rd(CT); check(q, 32'hA8);
    check({18'h0, flash_latch_data_o[3*14+:14]}, 32'h1234);
  endtask
  task automatic sc_prog_erase;
    start(8'h06); rd(CT); check(q, 32'h84);
    check(n_prog, 1);
    check({31'h0, flash_latch_data_o === {32{fspc_pkg::LATCH_BLANK}}}, 32'h1);
    start(8'h36); rd(CT); check(q, 32'hA4);
    check(n_erase, 1);
    check(n_prog, 1);
    check({31'h0, flash_latch_data_o === {32{fspc_pkg::LATCH_BLANK}}}, 32'h1);
  endtask
  task automatic sc_alt;
    wr(AL, 8'h05); start(8'h46); rd(CT); check(q, 32'hC4);
    check(n_prog, 1);
    // The program pulse comes after the start write, so wait for completion before counting
    wr(AL, 8'h02); start(8'h46); rd(CT); check(q, 32'hC4);
    check(n_prog, 2);
  endtask
  task automatic sc_modify;
    logic [7:0] lo;
    logic [7:0] hi;
    wr(AH, 8'h00); wr(AL, 8'h40); wr(CT, 8'h01);
    rd(DL); lo = q[7:0]; check(q, 32'hEA);
    rd(DH); hi = q[7:0]; check(q, 32'h2A);
    start(8'h16); rd(CT); check(q, 32'h84);
    check(n_erase, 2);
    wr(DL, lo); wr(DH, hi); start(8'h06); rd(CT); check(q, 32'h84);
    check(n_prog, 3);
    wr(CT, 8'h01); rd(DL); check(q, {24'h0, lo});
    rd(DH); check(q, {24'h0, hi});
  endtask
  task automatic sc_warm;
    wr(DL, 8'h5A); wr(AL, 8'h11);
    @(posedge clk_i); rstn_i <= 1'b0;
    @(posedge clk_i); rstn_i <= 1'b1;
    rd(DL); check(q, 32'h5A);
    rd(AL); check(q, 32'h00);
  endtask
  initial begin
    rstn_i = 1'b0;
    avs_address_i = 5'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    sc_reset();
    sc_regs();
    sc_read();
    sc_latch();
    sc_prog_erase();
    sc_alt();
    sc_modify();
    sc_warm();
    summarize();
  end
endmodule
`default_nettype wire
